// >>> shared/spzc_pkg.sv
// Purpose: Constants and types for the serial port zero control block
// Assumes: Registers are reached over a word-addressed Avalon-MM slave
// Notes:   Byte address of a register is four times its index
package spzc_pkg;
    // Register indices (word addresses)
    localparam logic [3:0] IDX_CONTROL   = 4'h6;
    localparam logic [3:0] IDX_BUFFER    = 4'h7;
    localparam logic [3:0] IDX_MODE_EXT  = 4'h8;
    localparam logic [3:0] IDX_EV_STATUS = 4'h9;
    localparam logic [3:0] IDX_EV_MASK   = 4'hA;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    // Control register fields
    localparam int CTL_RX_DONE  = 0;
    localparam int CTL_TX_DONE  = 1;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_EN    = 4;
    localparam int CTL_MP_CLK   = 5;
    localparam int CTL_MODE_ONE = 6;
    localparam int CTL_MODE_ZERO = 7;
    // Mode extension register fields
    localparam int MX_FRAME_CHECK = 0;
    localparam int MX_RATE_DOUBLE = 1;
    localparam int MX_IRQ_ENABLE  = 2;
    // Event status and mask fields
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_FE = 2;
    localparam int EV_W  = 3;
    // Bit periods in ticks
    localparam logic [6:0] M0_DIV_SLOW  = 7'h0C;
    localparam logic [6:0] M0_DIV_FAST  = 7'h04;
    localparam logic [6:0] ASYNC_SLOW   = 7'h40;
    localparam logic [6:0] BAUD_FAST    = 7'h10;
    localparam logic [6:0] SYS_FAST     = 7'h20;
    // Frame bit counts, and bit indices inside a received frame
    localparam logic [3:0] LEN_M0    = 4'h8;
    localparam logic [3:0] LEN_M1    = 4'hA;
    localparam logic [3:0] LEN_M23   = 4'hB;
    localparam logic [3:0] IDX_LAST8 = 4'h7;
    localparam logic [3:0] IDX_NINTH = 4'h8;
    localparam logic [3:0] IDX_STOP3 = 4'h9;

    typedef enum logic [1:0] {
        MODE0 = 2'b00,
        MODE1 = 2'b01,
        MODE2 = 2'b10,
        MODE3 = 2'b11
    } spzc_mode_t;

    typedef enum logic {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } spzc_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10
    } spzc_rx_state_t;
endpackage : spzc_pkg

// >>> verilog/spzc_serial_port.sv
// Purpose: Four-mode serial port zero with control, buffer and interrupt
// Assumes: baud_tick is a one-cycle enable from a timer on clk
// Notes:   Mode 0 shifts data on the data pin and clocks it out on txd
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps

module spzc_serial_port (
    input  wire logic        clk,             // System clock, 25 MHz
    input  wire logic        rst,             // Synchronous reset
    input  wire logic [3:0]  avs_address,     // Word address
    input  wire logic        avs_read,        // Read request
    input  wire logic        avs_write,       // Write request
    input  wire logic [31:0] avs_writedata,   // Write data
    output logic      [31:0] avs_readdata,    // Read data
    output logic             avs_waitrequest, // Stall
    input  wire logic        baud_tick,       // Baud clock enable
    input  wire logic        data_pin_in,     // Receive data pin level
    output logic             data_pin_out,    // Mode 0 transmit data
    output logic             data_pin_oe_n,   // Low while driving
    output logic             txd,             // Async data or mode 0 clock
    output logic             irq              // Level interrupt
);
    function automatic logic [6:0] bit_period(input logic [1:0] m,
                                              input logic rate_doubler,
                                              input logic mp);
        if (m == spzc_pkg::MODE0)
            return mp ? spzc_pkg::M0_DIV_FAST : spzc_pkg::M0_DIV_SLOW;
        else if (m == spzc_pkg::MODE2)
            return rate_doubler ? spzc_pkg::SYS_FAST : spzc_pkg::ASYNC_SLOW;
        else
            return rate_doubler ? spzc_pkg::BAUD_FAST : spzc_pkg::ASYNC_SLOW;
    endfunction : bit_period

    function automatic logic [3:0] frame_len(input logic [1:0] m);
        if (m == spzc_pkg::MODE0)
            return spzc_pkg::LEN_M0;
        else if (m == spzc_pkg::MODE1)
            return spzc_pkg::LEN_M1;
        else
            return spzc_pkg::LEN_M23;
    endfunction : frame_len

    // Bus, control and status state
    logic       rx_done_reg, rx_done_next, tx_done_reg, tx_done_next;
    logic       rx_ninth_reg, rx_ninth_next, tx_ninth_reg, tx_ninth_next;
    logic       rx_en_reg, rx_en_next, mp_reg, mp_next;
    logic       mode_one_reg, mode_one_next, mode_zero_reg, mode_zero_next;
    logic       fe_reg, fe_next, fce_reg, fce_next;
    logic       rdbl_reg, rdbl_next, irq_en_reg, irq_en_next;
    logic [7:0] txbuf_reg, txbuf_next, rxbuf_reg, rxbuf_next;
    logic [2:0] ev_stat_reg, ev_stat_next, ev_mask_reg, ev_mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic       wait_reg, wait_next, irq_reg, irq_next;
    // Transmitter state
    spzc_pkg::spzc_tx_state_t tx_state_reg, tx_state_next;
    logic [10:0] tx_shift_reg, tx_shift_next;
    logic [3:0]  tx_cnt_reg, tx_cnt_next;
    logic [6:0]  tx_tick_reg, tx_tick_next;
    logic        tx_pend_reg, tx_pend_next;
    logic        txd_reg, txd_next, dout_reg, dout_next, doe_n_reg, doe_n_next;
    // Receiver state
    spzc_pkg::spzc_rx_state_t rx_state_reg, rx_state_next;
    logic [9:0]  rx_shift_reg, rx_shift_next;
    logic [3:0]  rx_cnt_reg, rx_cnt_next;
    logic [6:0]  rx_tick_reg, rx_tick_next;
    logic        pin_meta_reg, pin_sync_reg, pin_prev_reg;

    logic [1:0]  mode;
    logic [6:0]  period, half;
    logic        tick_en, wr, wr_ctl;
    logic        tx_done_set, rx_commit, rx_ninth_wr, fe_set, m0_clk_rx;
    logic [3:0]  len;

    assign mode    = {mode_zero_reg, mode_one_reg};
    assign period  = bit_period(mode, rdbl_reg, mp_reg);
    assign half    = {1'b0, period[6:1]};
    assign len     = frame_len(mode);
    assign tick_en = (mode == spzc_pkg::MODE1 || mode == spzc_pkg::MODE3)
                     ? baud_tick : 1'b1;
    assign wr      = avs_write & ~wait_reg;
    assign wr_ctl  = wr && avs_address == spzc_pkg::IDX_CONTROL;

    always_comb begin
        rx_done_next   = rx_commit | (wr_ctl ?
                         avs_writedata[spzc_pkg::CTL_RX_DONE] : rx_done_reg);
        tx_done_next   = tx_done_set | (wr_ctl ?
                         avs_writedata[spzc_pkg::CTL_TX_DONE] : tx_done_reg);
        rx_ninth_next  = rx_ninth_reg;
        tx_ninth_next  = tx_ninth_reg;
        rx_en_next     = rx_en_reg;
        mp_next        = mp_reg;
        mode_one_next  = mode_one_reg;
        mode_zero_next = mode_zero_reg;
        fe_next        = fe_reg;
        fce_next       = fce_reg;
        rdbl_next      = rdbl_reg;
        irq_en_next    = irq_en_reg;
        txbuf_next     = txbuf_reg;
        rxbuf_next     = rx_commit ? rx_shift_next[7:0] : rxbuf_reg;
        ev_stat_next   = ev_stat_reg;
        ev_mask_next   = ev_mask_reg;
        rdata_next     = rdata_reg;
        wait_next      = ~((avs_read | avs_write) & wait_reg);
        if (wr_ctl) begin
            rx_ninth_next = avs_writedata[spzc_pkg::CTL_RX_NINTH];
            tx_ninth_next = avs_writedata[spzc_pkg::CTL_TX_NINTH];
            rx_en_next    = avs_writedata[spzc_pkg::CTL_RX_EN];
            mp_next       = avs_writedata[spzc_pkg::CTL_MP_CLK];
            mode_one_next = avs_writedata[spzc_pkg::CTL_MODE_ONE];
            if (fce_reg)
                fe_next = avs_writedata[spzc_pkg::CTL_MODE_ZERO];
            else
                mode_zero_next = avs_writedata[spzc_pkg::CTL_MODE_ZERO];
        end
        if (wr && avs_address == spzc_pkg::IDX_BUFFER)
            txbuf_next = avs_writedata[7:0];
        if (wr && avs_address == spzc_pkg::IDX_MODE_EXT) begin
            fce_next    = avs_writedata[spzc_pkg::MX_FRAME_CHECK];
            rdbl_next   = avs_writedata[spzc_pkg::MX_RATE_DOUBLE];
            irq_en_next = avs_writedata[spzc_pkg::MX_IRQ_ENABLE];
        end
        if (wr && avs_address == spzc_pkg::IDX_EV_STATUS)
            ev_stat_next = ev_stat_reg & ~avs_writedata[spzc_pkg::EV_W-1:0];
        if (wr && avs_address == spzc_pkg::IDX_EV_MASK)
            ev_mask_next = avs_writedata[spzc_pkg::EV_W-1:0];
        // Hardware events win over a clear in the same cycle
        if (rx_ninth_wr)
            rx_ninth_next = rx_shift_next[spzc_pkg::IDX_NINTH];
        if (fe_set)
            fe_next = 1'b1;
        ev_stat_next = ev_stat_next | {fe_set, tx_done_set, rx_commit};
        if (avs_read && wait_reg) begin
            rdata_next = '0;
            unique case (avs_address)
                spzc_pkg::IDX_CONTROL:
                    rdata_next[7:0] = {fce_reg ? fe_reg : mode_zero_reg,
                                       mode_one_reg, mp_reg, rx_en_reg,
                                       tx_ninth_reg, rx_ninth_reg,
                                       tx_done_reg, rx_done_reg};
                spzc_pkg::IDX_BUFFER:    rdata_next[7:0] = rxbuf_reg;
                spzc_pkg::IDX_MODE_EXT:
                    rdata_next[2:0] = {irq_en_reg, rdbl_reg, fce_reg};
                spzc_pkg::IDX_EV_STATUS: rdata_next[2:0] = ev_stat_reg;
                spzc_pkg::IDX_EV_MASK:   rdata_next[2:0] = ev_mask_reg;
                default:                 rdata_next = '0;
            endcase
        end
        // Gate by the enable so masking alone cannot raise a request
        irq_next = irq_en_reg & |(ev_stat_reg & ev_mask_reg);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            {rx_done_reg, tx_done_reg, rx_ninth_reg, tx_ninth_reg} <= 4'h0;
            {rx_en_reg, mp_reg, mode_one_reg, mode_zero_reg} <= 4'h0;
            fe_reg      <= 1'b0;
            fce_reg     <= 1'b0;
            rdbl_reg    <= 1'b0;
            irq_en_reg  <= 1'b0;
            txbuf_reg   <= spzc_pkg::RESET_BYTE;
            rxbuf_reg   <= spzc_pkg::RESET_BYTE;
            ev_stat_reg <= 3'h0;
            ev_mask_reg <= 3'h0;
            rdata_reg   <= 32'h0;
            wait_reg    <= 1'b1;
            irq_reg     <= 1'b0;
        end else begin
            rx_done_reg   <= rx_done_next;
            tx_done_reg   <= tx_done_next;
            rx_ninth_reg  <= rx_ninth_next;
            tx_ninth_reg  <= tx_ninth_next;
            rx_en_reg     <= rx_en_next;
            mp_reg        <= mp_next;
            mode_one_reg  <= mode_one_next;
            mode_zero_reg <= mode_zero_next;
            fe_reg        <= fe_next;
            fce_reg       <= fce_next;
            rdbl_reg      <= rdbl_next;
            irq_en_reg    <= irq_en_next;
            txbuf_reg     <= txbuf_next;
            rxbuf_reg     <= rxbuf_next;
            ev_stat_reg   <= ev_stat_next;
            ev_mask_reg   <= ev_mask_next;
            rdata_reg     <= rdata_next;
            wait_reg      <= wait_next;
            irq_reg       <= irq_next;
        end
    end

    // Transmitter and pin drivers
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_tick_next  = tx_tick_reg;
        tx_pend_next  = tx_pend_reg |
                        (wr && avs_address == spzc_pkg::IDX_BUFFER);
        tx_done_set   = 1'b0;
        txd_next      = (rx_state_reg == spzc_pkg::RX_DATA &&
                         mode == spzc_pkg::MODE0) ? m0_clk_rx : 1'b1;
        dout_next     = 1'b1;
        doe_n_next    = 1'b1;
        unique case (tx_state_reg)
            spzc_pkg::TX_IDLE: begin
                // Mode 0 shares the pins, so wait out a reception
                if (tx_pend_reg && !(mode == spzc_pkg::MODE0 &&
                    rx_state_reg != spzc_pkg::RX_IDLE)) begin
                    tx_state_next = spzc_pkg::TX_SHIFT;
                    // A write in the start cycle stays queued
                    tx_pend_next  = wr && avs_address == spzc_pkg::IDX_BUFFER;
                    tx_cnt_next   = 4'h0;
                    tx_tick_next  = 7'h00;
                    if (mode == spzc_pkg::MODE0)
                        tx_shift_next = {3'h7, txbuf_reg};
                    else
                        tx_shift_next = {1'b1, (mode == spzc_pkg::MODE1) |
                                         tx_ninth_reg, txbuf_reg, 1'b0};
                end
            end
            spzc_pkg::TX_SHIFT: begin
                if (mode == spzc_pkg::MODE0) begin
                    dout_next  = tx_shift_reg[0];
                    doe_n_next = 1'b0;
                    txd_next   = tx_tick_reg >= half;
                end else begin
                    txd_next = tx_shift_reg[0];
                end
                if (tick_en) begin
                    if (tx_tick_reg == period - 7'h01) begin
                        tx_tick_next  = 7'h00;
                        tx_shift_next = {1'b1, tx_shift_reg[10:1]};
                        tx_cnt_next   = tx_cnt_reg + 4'h1;
                        // Last data bit is just before any stop bit
                        if (tx_cnt_reg == ((mode == spzc_pkg::MODE0) ?
                            spzc_pkg::IDX_LAST8 : len - 4'h2))
                            tx_done_set = 1'b1;
                        if (tx_cnt_reg == len - 4'h1)
                            tx_state_next = spzc_pkg::TX_IDLE;
                    end else begin
                        tx_tick_next = tx_tick_reg + 7'h01;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_state_reg <= spzc_pkg::TX_IDLE;
            tx_shift_reg <= 11'h7FF;
            tx_cnt_reg   <= 4'h0;
            tx_tick_reg  <= 7'h00;
            tx_pend_reg  <= 1'b0;
            txd_reg      <= 1'b1;
            dout_reg     <= 1'b1;
            doe_n_reg    <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_tick_reg  <= tx_tick_next;
            tx_pend_reg  <= tx_pend_next;
            txd_reg      <= txd_next;
            dout_reg     <= dout_next;
            doe_n_reg    <= doe_n_next;
        end
    end

    // Receiver
    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_tick_next  = rx_tick_reg;
        rx_commit     = 1'b0;
        rx_ninth_wr   = 1'b0;
        fe_set        = 1'b0;
        m0_clk_rx     = rx_tick_reg >= half;
        unique case (rx_state_reg)
            spzc_pkg::RX_IDLE: begin
                rx_tick_next = 7'h00;
                rx_cnt_next  = 4'h0;
                if (rx_en_reg) begin
                    if (mode == spzc_pkg::MODE0) begin
                        if (!rx_done_reg && tx_state_reg == spzc_pkg::TX_IDLE
                            && !tx_pend_reg)
                            rx_state_next = spzc_pkg::RX_DATA;
                    end else if (pin_prev_reg && !pin_sync_reg) begin
                        rx_state_next = spzc_pkg::RX_START;
                    end
                end
            end
            spzc_pkg::RX_START: begin
                if (tick_en) begin
                    if (rx_tick_reg == half - 7'h01) begin
                        rx_tick_next  = 7'h00;
                        // A glitch shorter than half a bit is rejected
                        rx_state_next = pin_sync_reg ? spzc_pkg::RX_IDLE
                                                     : spzc_pkg::RX_DATA;
                    end else begin
                        rx_tick_next = rx_tick_reg + 7'h01;
                    end
                end
            end
            spzc_pkg::RX_DATA: begin
                if (tick_en && rx_tick_reg == period - 7'h01) begin
                    rx_tick_next = 7'h00;
                    rx_cnt_next  = rx_cnt_reg + 4'h1;
                    rx_shift_next[rx_cnt_reg] = pin_sync_reg;
                    if (mode == spzc_pkg::MODE0) begin
                        if (rx_cnt_reg == spzc_pkg::IDX_LAST8) begin
                            rx_commit     = 1'b1;
                            rx_state_next = spzc_pkg::RX_IDLE;
                        end
                    end else if (rx_cnt_reg == spzc_pkg::IDX_NINTH) begin
                        // Stop bit in mode 1, ninth bit in modes 2 and 3
                        if (!mp_reg || pin_sync_reg) begin
                            rx_commit   = 1'b1;
                            rx_ninth_wr = 1'b1;
                        end
                        if (mode == spzc_pkg::MODE1) begin
                            fe_set        = fce_reg & ~pin_sync_reg;
                            rx_state_next = spzc_pkg::RX_IDLE;
                        end
                    end else if (rx_cnt_reg == spzc_pkg::IDX_STOP3) begin
                        fe_set        = fce_reg & ~pin_sync_reg;
                        rx_state_next = spzc_pkg::RX_IDLE;
                    end
                end else if (tick_en) begin
                    rx_tick_next = rx_tick_reg + 7'h01;
                end
            end
            default: rx_state_next = spzc_pkg::RX_IDLE;
        endcase
        if (!rx_en_reg)
            rx_state_next = spzc_pkg::RX_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_state_reg <= spzc_pkg::RX_IDLE;
            rx_shift_reg <= 10'h000;
            rx_cnt_reg   <= 4'h0;
            rx_tick_reg  <= 7'h00;
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_tick_reg  <= rx_tick_next;
            pin_meta_reg <= data_pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign data_pin_out    = dout_reg;
    assign data_pin_oe_n   = doe_n_reg;
    assign txd             = txd_reg;
    assign irq             = irq_reg;
endmodule : spzc_serial_port

// >>> verification/spzc_serial_port_chk.sv
// Purpose: Bus and pin assertions for the serial port block
// Assumes: Sees only the top module ports
// Notes:   The mode is internal, so pin checks hold in every mode
`timescale 1ns/1ps
module spzc_serial_port_chk (
    input wire logic        clk,             // System clock
    input wire logic        rst,             // Synchronous reset
    input wire logic [3:0]  avs_address,     // Word address
    input wire logic        avs_read,        // Read request
    input wire logic        avs_write,       // Write request
    input wire logic [31:0] avs_readdata,    // Read data
    input wire logic        avs_waitrequest, // Stall
    input wire logic        data_pin_out,    // Mode 0 data out
    input wire logic        data_pin_oe_n,   // Low while driving
    input wire logic        txd,             // Serial out
    input wire logic        irq              // Level interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic unmapped;
    assign unmapped = (avs_address < 4'h6) || (avs_address > 4'hA);
    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rd_s;
        avs_read && avs_waitrequest;
    endsequence
    chk_wait_one: assert property (req_s |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    chk_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_no_request: assert property (!(avs_read || avs_write)
        && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    chk_reset_outs: assert property ($fell(rst) |-> txd && data_pin_oe_n
        && !irq && avs_waitrequest && avs_readdata == 32'h0)
        else $error("outputs not at reset level");
    chk_unmapped_zero: assert property (rd_s ##0 unmapped
        |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_reserved_high: assert property (rd_s |=> avs_readdata[31:8] == 24'h0)
        else $error("reserved read bits set");
    chk_ext_bits: assert property (rd_s ##0 avs_address == 4'h8
        |=> avs_readdata[7:3] == 5'h0)
        else $error("mode extension reserved bits set");
    chk_bit_width: assert property ($fell(txd) |-> !txd [*2])
        else $error("serial low level shorter than two cycles");
    chk_pin_idle: assert property (data_pin_oe_n |-> data_pin_out)
        else $error("data pin out not high while released");
endmodule : spzc_serial_port_chk

// >>> verification/spzc_peer.sv
// Purpose: Serial peer on the line side of the port
// Assumes: Bit period given in system clocks by the caller
// Notes:   Line idles high; drives change just after a rising edge
`timescale 1ns/1ps
module spzc_peer (
    input  wire logic clk,  // System clock
    input  wire logic txd,  // Device serial out
    output logic      line  // Line into the device
);
    initial line = 1'b1;
    // Start bit, then nb bits of v LSB first, then idle
    task automatic send(input logic [9:0] v, input int nb, input int per);
        line <= 1'b0;
        repeat (per) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            line <= v[i];
            repeat (per) @(posedge clk);
        end
        line <= 1'b1;
    endtask : send
    // Samples the start bit and nb more bits at mid period
    task automatic recv(input int nb, input int per, output logic [10:0] b);
        b = '0;
        while (txd !== 1'b0) @(posedge clk);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i <= nb; i++) begin
            b[i] = txd;
            repeat (per) @(posedge clk);
        end
    endtask : recv
endmodule : spzc_peer

// >>> verification/spzc_serial_port_tb_top.sv
// Purpose: Self-checking bench for the serial port block
// Assumes: Baud tick every fourth clock
// Notes:   Mode 0 transmit is checked at the rising edges of its shift clock
`timescale 1ns/1ps
module spzc_serial_port_tb_top;
    logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic        baud_tick = 1'b0, peer_line, data_pin_in, data_pin_out;
    logic        data_pin_oe_n, txd, irq, avs_waitrequest, n9, i0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [10:0] bits;
    logic [7:0]  d, c;
    int          fail_count = 0, checks_done = 0, cyc = 0, bt = 0;
    int          seed = 21977;
    time         t0;
    // The device owns the pin only while its enable is low
    assign data_pin_in = data_pin_oe_n ? peer_line : data_pin_out;
    spzc_serial_port spzc_serial_port_i (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .baud_tick(baud_tick), .data_pin_in(data_pin_in),
        .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
        .txd(txd), .irq(irq));
    spzc_peer spzc_peer_i (.clk(clk), .txd(txd), .line(peer_line));
    always #20 clk = ~clk;
    task automatic final_report();
        $display("mismatches %0d checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        bt <= (bt + 1) % 4;
        baud_tick <= (bt == 3);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] w);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= w;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    function automatic logic [10:0] frame(input logic [7:0] b, input logic n);
        return {1'b1, n, b, 1'b0};
    endfunction : frame
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, spzc_pkg::IDX_CONTROL, 0);
        chk(rd, {24'h0, spzc_pkg::RESET_BYTE});
        bus(0, spzc_pkg::IDX_MODE_EXT, 0);
        chk(rd, 32'h0);
        bus(0, 4'hF, 0);
        chk(rd, 32'h0);
        for (int k = 0; k < 4; k++) begin
            c = 8'($random(seed)) & 8'hEF;
            bus(1, spzc_pkg::IDX_CONTROL, {24'h0, c});
            bus(0, spzc_pkg::IDX_CONTROL, 0);
            chk(rd, {24'h0, c});
        end
        d = 8'($random(seed));
        n9 = 1'($random(seed));
        bus(1, spzc_pkg::IDX_CONTROL, 32'h0);
        bus(1, spzc_pkg::IDX_EV_STATUS, 32'hFF);
        bus(1, spzc_pkg::IDX_MODE_EXT, 32'h02);
        bus(1, spzc_pkg::IDX_CONTROL, {24'h0, 4'h8, n9, 3'h0});
        bus(1, spzc_pkg::IDX_BUFFER, {24'h0, d});
        spzc_peer_i.recv(10, 32, bits);
        chk({21'h0, bits}, {21'h0, frame(d, n9)});
        bus(0, spzc_pkg::IDX_CONTROL, 0);
        chk(rd & 32'h2, 32'h2);
        chk(32'(irq), 32'h0);
        bus(1, spzc_pkg::IDX_MODE_EXT, 32'h06);
        bus(1, spzc_pkg::IDX_EV_MASK, 32'h0);
        repeat (3) @(posedge clk);
        i0 = irq;
        bus(1, spzc_pkg::IDX_EV_MASK, 32'hF);
        repeat (3) @(posedge clk);
        chk({30'h0, i0, irq}, 32'h1);
        bus(1, spzc_pkg::IDX_EV_STATUS, 32'hFF);
        bus(1, spzc_pkg::IDX_CONTROL, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        bus(1, spzc_pkg::IDX_CONTROL, 32'hB0);
        spzc_peer_i.send(10'(frame(8'h5A, 1'b0) >> 1), 10, 32);
        bus(0, spzc_pkg::IDX_CONTROL, 0);
        chk(rd & 32'h1, 32'h0);
        spzc_peer_i.send(10'(frame(d, 1'b1) >> 1), 10, 32);
        bus(0, spzc_pkg::IDX_CONTROL, 0);
        chk(rd & 32'h5, 32'h5);
        bus(0, spzc_pkg::IDX_BUFFER, 0);
        chk(rd, {24'h0, d});
        bus(1, spzc_pkg::IDX_CONTROL, 32'h70);
        bus(1, spzc_pkg::IDX_MODE_EXT, 32'h03);
        spzc_peer_i.send({2'h0, d}, 9, 64);
        bus(0, spzc_pkg::IDX_CONTROL, 0);
        chk(rd & 32'h81, 32'h80);
        bus(0, spzc_pkg::IDX_MODE_EXT, 0);
        chk(rd, 32'h3);
        bus(1, spzc_pkg::IDX_CONTROL, 32'hF0);
        spzc_peer_i.send({2'h1, ~d}, 9, 64);
        bus(0, spzc_pkg::IDX_CONTROL, 0);
        chk(rd & 32'h1, 32'h1);
        bus(0, spzc_pkg::IDX_BUFFER, 0);
        chk(rd, {24'h0, ~d});
        bus(1, spzc_pkg::IDX_CONTROL, 32'h20);
        bus(1, spzc_pkg::IDX_BUFFER, {24'h0, c});
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            bits[i] = data_pin_out;
            if (i == 0) t0 = $time;
        end
        chk(32'($time - t0), 32'(7 * 4 * 40));
        chk({24'h0, bits[7:0]}, {24'h0, c});
        repeat (8) @(posedge clk);
        bus(0, spzc_pkg::IDX_CONTROL, 0);
        chk(rd & 32'h2, 32'h2);
        final_report();
    end
endmodule : spzc_serial_port_tb_top
bind spzc_serial_port spzc_serial_port_chk spzc_serial_port_chk_i (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_pin_out(data_pin_out),
    .data_pin_oe_n(data_pin_oe_n), .txd(txd), .irq(irq));
